/* File: shared/ccx_pkg.sv */
package ccx_pkg;
   // Opcode patterns
   localparam logic [3:0] CCX_CALL_TOP = 4'h9;
   localparam logic [6:0] CCX_CLEAR_FILE_TOP = 7'h03;
   localparam logic [11:0] CCX_CLEAR_WORK_CODE = 12'h040;
   localparam logic [11:0] CCX_WDOG_CLEAR_CODE = 12'h004;
   // Widths and stack depth
   localparam int CCX_PC_W = 11;
   localparam int CCX_DATA_W = 16;
   localparam int CCX_ADDR_W = 4;
   localparam int CCX_STACK_DEPTH = 2;
   // Register offsets
   localparam logic [3:0] CCX_REG_CTRL = 4'h0;
   localparam logic [3:0] CCX_REG_STATUS = 4'h1;
   localparam logic [3:0] CCX_REG_PC = 4'h2;
   localparam logic [3:0] CCX_REG_WORK = 4'h3;
   localparam logic [3:0] CCX_REG_WDOG = 4'h4;
   localparam logic [3:0] CCX_REG_PRESC = 4'h5;
   localparam logic [3:0] CCX_REG_STACK = 4'h6;
   // Field positions
   localparam int CCX_CTRL_PSA_BIT = 0;
   localparam int CCX_CTRL_PAGE_LO = 1;
   localparam int CCX_STAT_Z_BIT = 0;
   localparam int CCX_STAT_PWRDN_BIT = 1;
   localparam int CCX_STAT_TIMEOUT_BIT = 2;
   // Reset values
   localparam logic [10:0] CCX_PC_RESET = 11'h000;
   localparam logic [7:0] CCX_ZERO8 = 8'h00;
   localparam logic [1:0] CCX_PAGE_RESET = 2'h0;
   localparam logic CCX_PSA_RESET = 1'b0;

   typedef enum logic [2:0] {
      CCX_OP_NONE = 3'b000,
      CCX_OP_CALL = 3'b001,
      CCX_OP_CLEAR_FILE = 3'b010,
      CCX_OP_CLEAR_WORK = 3'b011,
      CCX_OP_WDOG_CLEAR = 3'b100
   } ccx_op_type;

   typedef struct packed {
      ccx_op_type op;
      logic [7:0] target;
      logic [4:0] faddr;
   } ccx_dec_type;
endpackage : ccx_pkg

/* File: logic/ccx_decode.sv */
`timescale 1ns/1ns
module ccx_decode
   import ccx_pkg::*;
(
   input wire logic [11:0] instr, // Instruction word
   output ccx_dec_type dec // Decoded operation
);
   always_comb begin
      dec.op = CCX_OP_NONE;
      dec.target = instr[7:0];
      dec.faddr = instr[4:0];
      if (instr[11:8] == CCX_CALL_TOP) begin
         dec.op = CCX_OP_CALL; // [RQ1]
      end else if (instr[11:5] == CCX_CLEAR_FILE_TOP) begin
         dec.op = CCX_OP_CLEAR_FILE; // [RQ4]
      end else if (instr == CCX_CLEAR_WORK_CODE) begin
         dec.op = CCX_OP_CLEAR_WORK; // [RQ5]
      end else if (instr == CCX_WDOG_CLEAR_CODE) begin
         dec.op = CCX_OP_WDOG_CLEAR; // [RQ6]
      end
   end
endmodule : ccx_decode

/* File: logic/ccx_exec_top.sv */
// Notes on behaviour
// [RQ1] Call pushes next address onto stack
// [RQ2] Call loads k, page bits, clears bit 8
// [RQ3] Call takes two cycles, flags untouched
// [RQ4] Clear file register zeroes it, sets zero
// [RQ5] Clear working register zeroes it, sets zero
// [RQ6] Watchdog clear zeroes watchdog counter
// [RQ7] Also zeroes prescaler when assigned to watchdog
// [RQ8] Watchdog clear sets timeout and powerdown flags
`timescale 1ns/1ns
module ccx_exec_top
   import ccx_pkg::*;
#(
   parameter int PC_W = CCX_PC_W,
   parameter int DEPTH = CCX_STACK_DEPTH
)(
   input wire logic clk, // Clock, 100 MHz
   input wire logic reset_n, // Async reset, active low
   input wire logic instr_valid, // Instruction offered
   input wire logic [11:0] instr, // Instruction word
   output logic instr_ready, // Core can take an instruction
   input wire logic watchdog_tick, // Watchdog counter advance
   input wire logic prescaler_tick, // Prescaler advance
   input wire logic [CCX_ADDR_W-1:0] bus_addr, // Register address
   input wire logic [CCX_DATA_W-1:0] bus_wdata, // Write data
   input wire logic bus_wr, // Write strobe
   input wire logic bus_rd, // Read strobe
   output logic [CCX_DATA_W-1:0] bus_rdata_ff, // Read data, cycle after strobe
   output logic freg_wr_ff, // File register write pulse
   output logic [4:0] freg_addr_ff, // File register address
   output logic [7:0] freg_data_ff, // File register data
   output logic [PC_W-1:0] pc_ff // Program counter
);
   ////////////////////////////////////////////////////////////////////////
   ccx_dec_type dec;
   logic take;
   logic call_busy_ff, nxt_call_busy;
   logic [PC_W-1:0] nxt_pc;
   logic [PC_W-1:0] stack_ff [DEPTH];
   logic [PC_W-1:0] nxt_stack [DEPTH];
   logic [7:0] work_ff, nxt_work;
   logic zero_ff, nxt_zero;
   logic timeout_flag_n_ff, nxt_timeout_flag_n;
   logic powerdown_flag_n_ff, nxt_powerdown_flag_n;
   logic [7:0] watchdog_counter_ff, nxt_watchdog_counter;
   logic [7:0] presc_ff, nxt_presc;
   logic psa_ff, nxt_psa;
   logic [1:0] page_ff, nxt_page;
   logic nxt_freg_wr;
   logic [4:0] nxt_freg_addr;
   logic [CCX_DATA_W-1:0] nxt_rdata;

   ccx_decode u_decode (
      .instr(instr),
      .dec(dec)
   );

   // Second call cycle is a dead fetch slot
   assign instr_ready = ~call_busy_ff; // [RQ3]
   assign take = instr_valid & instr_ready;

   ////////////////////////////////////////////////////////////////////////
   // Program counter and return stack
   always_comb begin
      nxt_pc = pc_ff;
      nxt_call_busy = 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
         nxt_stack[i] = stack_ff[i];
      end
      if (take) begin
         nxt_pc = PC_W'(pc_ff + 1'b1);
         if (dec.op == CCX_OP_CALL) begin
            nxt_stack[0] = PC_W'(pc_ff + 1'b1); // [RQ1]
            for (int i = 1; i < DEPTH; i++) begin
               nxt_stack[i] = stack_ff[i-1];
            end
            nxt_pc = PC_W'({page_ff, 1'b0, dec.target}); // [RQ2]
            nxt_call_busy = 1'b1; // [RQ3]
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_ff <= PC_W'(CCX_PC_RESET);
         call_busy_ff <= 1'b0;
         for (int i = 0; i < DEPTH; i++) begin
            stack_ff[i] <= PC_W'(CCX_PC_RESET);
         end
      end else begin
         pc_ff <= nxt_pc;
         call_busy_ff <= nxt_call_busy;
         stack_ff <= nxt_stack;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Working register, flags, watchdog, prescaler, control
   always_comb begin
      nxt_work = work_ff;
      nxt_zero = zero_ff;
      nxt_timeout_flag_n = timeout_flag_n_ff;
      nxt_powerdown_flag_n = powerdown_flag_n_ff;
      nxt_watchdog_counter = watchdog_tick ? 8'(watchdog_counter_ff + 1'b1) : watchdog_counter_ff;
      nxt_presc = prescaler_tick ? 8'(presc_ff + 1'b1) : presc_ff;
      nxt_psa = psa_ff;
      nxt_page = page_ff;
      nxt_freg_wr = 1'b0;
      nxt_freg_addr = freg_addr_ff;
      // Software writes first, instruction effects override
      if (bus_wr) begin
         case (bus_addr)
            CCX_REG_CTRL: begin
               nxt_psa = bus_wdata[CCX_CTRL_PSA_BIT];
               nxt_page = bus_wdata[CCX_CTRL_PAGE_LO +: 2];
            end
            CCX_REG_STATUS: begin
               nxt_zero = bus_wdata[CCX_STAT_Z_BIT];
               nxt_powerdown_flag_n = bus_wdata[CCX_STAT_PWRDN_BIT];
               nxt_timeout_flag_n = bus_wdata[CCX_STAT_TIMEOUT_BIT];
            end
            CCX_REG_WORK: begin
               nxt_work = bus_wdata[7:0];
            end
            default: begin
            end
         endcase
      end
      if (take) begin
         case (dec.op)
            CCX_OP_CLEAR_FILE: begin
               nxt_freg_wr = 1'b1; // [RQ4]
               nxt_freg_addr = dec.faddr;
               nxt_zero = 1'b1; // [RQ4]
            end
            CCX_OP_CLEAR_WORK: begin
               nxt_work = CCX_ZERO8; // [RQ5]
               nxt_zero = 1'b1; // [RQ5]
            end
            CCX_OP_WDOG_CLEAR: begin
               nxt_watchdog_counter = CCX_ZERO8; // [RQ6]
               if (psa_ff) begin
                  nxt_presc = CCX_ZERO8; // [RQ7]
               end
               nxt_timeout_flag_n = 1'b1; // [RQ8]
               nxt_powerdown_flag_n = 1'b1; // [RQ8]
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         work_ff <= CCX_ZERO8;
         zero_ff <= 1'b0;
         timeout_flag_n_ff <= 1'b1;
         powerdown_flag_n_ff <= 1'b1;
         watchdog_counter_ff <= CCX_ZERO8;
         presc_ff <= CCX_ZERO8;
         psa_ff <= CCX_PSA_RESET;
         page_ff <= CCX_PAGE_RESET;
         freg_wr_ff <= 1'b0;
         freg_addr_ff <= 5'h00;
         freg_data_ff <= CCX_ZERO8;
      end else begin
         work_ff <= nxt_work;
         zero_ff <= nxt_zero;
         timeout_flag_n_ff <= nxt_timeout_flag_n;
         powerdown_flag_n_ff <= nxt_powerdown_flag_n;
         watchdog_counter_ff <= nxt_watchdog_counter;
         presc_ff <= nxt_presc;
         psa_ff <= nxt_psa;
         page_ff <= nxt_page;
         freg_wr_ff <= nxt_freg_wr;
         freg_addr_ff <= nxt_freg_addr;
         freg_data_ff <= CCX_ZERO8; // [RQ4]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read port
   always_comb begin
      nxt_rdata = '0;
      if (bus_rd) begin
         case (bus_addr)
            CCX_REG_CTRL: nxt_rdata = CCX_DATA_W'({page_ff, psa_ff});
            CCX_REG_STATUS: nxt_rdata = CCX_DATA_W'({timeout_flag_n_ff, powerdown_flag_n_ff, zero_ff});
            CCX_REG_PC: nxt_rdata = CCX_DATA_W'(pc_ff);
            CCX_REG_WORK: nxt_rdata = CCX_DATA_W'(work_ff);
            CCX_REG_WDOG: nxt_rdata = CCX_DATA_W'(watchdog_counter_ff);
            CCX_REG_PRESC: nxt_rdata = CCX_DATA_W'(presc_ff);
            CCX_REG_STACK: nxt_rdata = CCX_DATA_W'(stack_ff[0]);
            default: nxt_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_rdata_ff <= '0;
      end else begin
         bus_rdata_ff <= nxt_rdata;
      end
   end
endmodule : ccx_exec_top

/* File: tb/ccx_exec_top_asserts.sv */
`timescale 1ns/1ns
module ccx_exec_chk
   import ccx_pkg::*;
#(
   parameter int PC_W = CCX_PC_W
)(
   input wire logic clk, // Clock
   input wire logic reset_n, // Reset
   input wire logic instr_valid, // Offered
   input wire logic [11:0] instr, // Word
   input wire logic instr_ready, // Ready
   input wire logic [CCX_ADDR_W-1:0] bus_addr, // Address
   input wire logic bus_wr, // Write
   input wire logic bus_rd, // Read
   input wire logic [CCX_DATA_W-1:0] bus_rdata_ff, // Read data
   input wire logic freg_wr_ff, // Clear pulse
   input wire logic [4:0] freg_addr_ff, // Clear address
   input wire logic [7:0] freg_data_ff, // Clear data
   input wire logic [PC_W-1:0] pc_ff // Counter
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   sequence s_op(logic [11:0] code, logic [11:0] mask);
      instr_valid && instr_ready && (instr & mask) == code;
   endsequence
   a_call_target: assert property (s_op(12'h900, 12'hF00) |=> pc_ff[8:0] == {1'b0, $past(instr[7:0])})
      else $error("call target wrong");
   a_call_stall: assert property (s_op(12'h900, 12'hF00) |=> !instr_ready ##1 instr_ready)
      else $error("call not two cycles");
   a_stall_hold: assert property (!instr_ready |=> $stable(pc_ff))
      else $error("counter moved in dead cycle");
   sequence s_status_read;
      !bus_wr ##1 (bus_rd && bus_addr == CCX_REG_STATUS);
   endsequence
   a_clear_file_pulse: assert property (s_op(12'h060, 12'hFE0) |=> freg_wr_ff && freg_addr_ff == $past(instr[4:0]))
      else $error("clear pulse wrong");
   a_clear_file_only: assert property (freg_wr_ff |-> freg_data_ff == 8'h00 && $past(instr[11:5]) == CCX_CLEAR_FILE_TOP)
      else $error("stray clear pulse");
   a_clear_work_step: assert property (s_op(CCX_CLEAR_WORK_CODE, 12'hFFF) |=> pc_ff == $past(pc_ff) + 1'b1)
      else $error("clear working step wrong");
   a_wdog_step: assert property (s_op(CCX_WDOG_CLEAR_CODE, 12'hFFF) |=> pc_ff == $past(pc_ff) + 1'b1)
      else $error("watchdog clear step wrong");
   a_status_wdog: assert property (s_op(CCX_WDOG_CLEAR_CODE, 12'hFFF) ##1 s_status_read |=> bus_rdata_ff[2:1] == 2'b11)
      else $error("flags not set");
endmodule : ccx_exec_chk
bind ccx_exec_top ccx_exec_chk #(.PC_W(PC_W)) u_chk (.clk, .reset_n, .instr_valid, .instr, .instr_ready,
   .bus_addr, .bus_wr, .bus_rd, .bus_rdata_ff, .freg_wr_ff, .freg_addr_ff, .freg_data_ff, .pc_ff);

/* File: tb/test_ccx_exec_top.sv */
`timescale 1ns/1ns
module test_ccx_exec_top;
   import ccx_pkg::*;
   logic clk = 0, reset_n = 0, instr_valid = 0, watchdog_tick = 0, prescaler_tick = 0, bus_wr = 0, bus_rd = 0;
   logic [11:0] instr = 0;
   logic [3:0] bus_addr = 0;
   logic [15:0] bus_wdata = 0, bus_rdata_ff;
   logic instr_ready, freg_wr_ff;
   logic [4:0] freg_addr_ff;
   logic [7:0] freg_data_ff;
   logic [10:0] pc_ff;
   int n_mismatch = 0, n_compared = 0;
   // Instruction, counter after, clear pulse
   logic [23:0] rows [6] = '{{12'h065, 11'h001, 1'b1}, {12'h07F, 11'h002, 1'b1}, {12'h040, 11'h003, 1'b0},
      {12'h004, 11'h004, 1'b0}, {12'h9FF, 11'h0FF, 1'b0}, {12'h900, 11'h000, 1'b0}};
   ccx_exec_top u_ccx_exec_top (.clk, .reset_n, .instr_valid, .instr, .instr_ready, .watchdog_tick,
      .prescaler_tick, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_ff, .freg_wr_ff, .freg_addr_ff,
      .freg_data_ff, .pc_ff);
   always #5 clk = ~clk;
   ////////////////////////////////////////
   task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      bus_wr <= 1;
      bus_addr <= a;
      bus_wdata <= d;
      @(posedge clk);
      bus_wr <= 0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      bus_rd <= 1;
      bus_addr <= a;
      @(posedge clk);
      bus_rd <= 0;
      #1 chk("rdata", d, bus_rdata_ff);
   endtask : rd
   task exe(input logic [11:0] i);
      @(posedge clk);
      instr_valid <= 1;
      instr <= i;
      @(posedge clk);
      instr_valid <= 0;
      #1;
   endtask : exe
   task tick(input int n);
      @(posedge clk);
      watchdog_tick <= 1;
      prescaler_tick <= 1;
      repeat (n) @(posedge clk);
      watchdog_tick <= 0;
      prescaler_tick <= 0;
   endtask : tick
   task test_done;
      if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   ////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1;
      foreach (rows[i]) begin
         exe(rows[i][23:12]);
         chk("pc", 16'(rows[i][11:1]), 16'(pc_ff));
         chk("freg_wr", 16'(rows[i][0]), 16'(freg_wr_ff));
         chk("freg_data", 16'h0000, 16'(freg_data_ff));
         if (rows[i][0]) chk("freg_addr", 16'(rows[i][16:12]), 16'(freg_addr_ff));
         if (rows[i][23:20] == CCX_CALL_TOP) chk("ready", 16'h0000, 16'(instr_ready));
      end
      wr(CCX_REG_CTRL, 16'h0006);
      wr(CCX_REG_STATUS, 16'h0005);
      tick(3);
      exe(12'h912);
      chk("pc", 16'h0612, 16'(pc_ff));
      rd(CCX_REG_STACK, 16'h0001);
      rd(CCX_REG_STATUS, 16'h0005);
      exe(CCX_WDOG_CLEAR_CODE);
      rd(CCX_REG_STATUS, 16'h0007);
      rd(CCX_REG_WDOG, 16'h0000);
      rd(CCX_REG_PRESC, 16'h0003);
      wr(CCX_REG_CTRL, 16'h0007);
      tick(2);
      exe(CCX_WDOG_CLEAR_CODE);
      rd(CCX_REG_PRESC, 16'h0000);
      wr(CCX_REG_STATUS, 16'h0000);
      wr(CCX_REG_WORK, 16'h005A);
      exe(CCX_CLEAR_WORK_CODE);
      rd(CCX_REG_WORK, 16'h0000);
      rd(CCX_REG_STATUS, 16'h0001);
      rd(4'hF, 16'h0000);
      // Reset in mid-run
      @(posedge clk);
      reset_n <= 0;
      repeat (2) @(posedge clk);
      chk("pc", 16'h0000, 16'(pc_ff));
      chk("ready", 16'h0001, 16'(instr_ready));
      reset_n <= 1;
      rd(CCX_REG_STATUS, 16'h0006);
      // Clear beats same-cycle flag write and watchdog tick
      @(posedge clk);
      instr_valid <= 1;
      instr <= CCX_WDOG_CLEAR_CODE;
      watchdog_tick <= 1;
      bus_wr <= 1;
      bus_addr <= CCX_REG_STATUS;
      bus_wdata <= 16'h0001;
      @(posedge clk);
      instr_valid <= 0;
      watchdog_tick <= 0;
      bus_wr <= 0;
      rd(CCX_REG_STATUS, 16'h0007);
      rd(CCX_REG_WDOG, 16'h0000);
      test_done();
   end
   initial begin
      #20000;
      n_mismatch++;
      test_done();
   end
endmodule : test_ccx_exec_top
